// ==== hdl/fld_core.sv ====
// Purpose : fault latching, diagnosis word, thermal latch clear and sense selection
// Assumes : serial link mode with data out on rising edge, data in on falling edge
// Notes   : chip select high holds the link counters cleared; clock may stop between frames
module fld_core #(
   parameter int unsigned N_CH = fld_pkg::N_CH
) (
   input  wire logic            core_clk,
   input  wire logic            rst,
   // serial link
   input  wire logic            sclk,
   input  wire logic            cs_n,
   input  wire logic            mosi,
   output logic                 miso_o,
   output logic                 miso_oe,
   // analog side monitors
   input  wire logic [N_CH-1:0] chan_on_cmd,
   input  wire logic [N_CH-1:0] over_temp,
   input  wire logic [N_CH-1:0] over_load,
   input  wire logic [N_CH-1:0] dyn_temp_off,
   input  wire logic [N_CH-1:0] vds_above_thr,
   input  wire logic            ground_lost,
   // outputs
   output logic [N_CH-1:0]      gate_on,
   output logic [N_CH-1:0]      thermal_latch,
   output logic [N_CH-1:0]      channel_error_flag,
   output logic [N_CH-1:0]      sense_output_sel,
   output logic                 sense_output_en,
   output logic                 bypass_monitor_result
);

   localparam int unsigned FW  = fld_pkg::FRAME_W;
   localparam int unsigned SW  = fld_pkg::SEL_W;
   localparam int unsigned CW  = fld_pkg::CNT_W;
   localparam int unsigned SYW = 5 * N_CH + 5;

   // ==========================================================
   // link domain: outgoing shifter on rising serial clock edges
   logic [CW-1:0] rise_cnt_q;
   logic [FW-2:0] out_sh_q;
   logic [FW-1:0] resp_q;          // core-owned, frozen for the whole frame
   logic          clr_tog_q;
   logic          arm_tog_q;

   always_ff @(posedge sclk or posedge cs_n or posedge rst) begin
      if (rst || cs_n) begin
         rise_cnt_q <= '0;
         out_sh_q   <= '0;
         miso_o     <= 1'b0;
         miso_oe    <= 1'b0;
      end else begin
         miso_oe <= 1'b1;
         if (rise_cnt_q != fld_pkg::CNT_SAT) begin
            rise_cnt_q <= rise_cnt_q + 4'h1;
         end
         if (rise_cnt_q == '0) begin
            miso_o   <= resp_q[FW-1];
            out_sh_q <= resp_q[FW-2:0];
         end else begin
            miso_o   <= out_sh_q[FW-2];
            out_sh_q <= {out_sh_q[FW-3:0], 1'b0};
         end
      end
   end

   // edge events travel to the core as toggles
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         clr_tog_q <= 1'b0;
         arm_tog_q <= 1'b0;
      end else begin
         if (rise_cnt_q == fld_pkg::CLR_EDGE) begin
            clr_tog_q <= ~clr_tog_q;
         end
         if (rise_cnt_q == fld_pkg::ARM_EDGE) begin
            arm_tog_q <= ~arm_tog_q;
         end
      end
   end

   // ==========================================================
   // link domain: incoming shifter on falling serial clock edges
   logic [CW-1:0] fall_cnt_q;
   logic [FW-2:0] in_sh_q;
   logic [FW-1:0] cmd_word_q;
   logic          cmd_tog_q;

   always_ff @(negedge sclk or posedge cs_n or posedge rst) begin
      if (rst || cs_n) begin
         fall_cnt_q <= '0;
         in_sh_q    <= '0;
      end else begin
         if (fall_cnt_q != fld_pkg::CNT_SAT) begin
            fall_cnt_q <= fall_cnt_q + 4'h1;
         end
         in_sh_q <= {in_sh_q[FW-3:0], mosi};
      end
   end

   // command word stays stable until the next full frame, so the toggle alone crosses
   always_ff @(negedge sclk or posedge rst) begin
      if (rst) begin
         cmd_word_q <= '0;
         cmd_tog_q  <= 1'b0;
      end else if (!cs_n && fall_cnt_q == fld_pkg::LAST_FALL) begin
         cmd_word_q <= {in_sh_q, mosi};
         cmd_tog_q  <= ~cmd_tog_q;
      end
   end

   // ==========================================================
   // synchronisers into the core domain
   logic [SYW-1:0] sync_in;
   logic [SYW-1:0] sync_out;
   logic [N_CH-1:0] on_s;
   logic [N_CH-1:0] ot_s;
   logic [N_CH-1:0] ol_s;
   logic [N_CH-1:0] dyn_s;
   logic [N_CH-1:0] vds_s;
   logic            gnd_lost_s;
   logic            cs_n_s;
   logic            clr_tog_s;
   logic            arm_tog_s;
   logic            cmd_tog_s;

   assign sync_in = {cs_n, ground_lost, clr_tog_q, arm_tog_q, cmd_tog_q,
                     vds_above_thr, dyn_temp_off, over_load, over_temp, chan_on_cmd};

   fld_sync #(
      .WIDTH   (SYW),
      .RST_VAL ({1'b1, 1'b1, {(SYW-2){1'b0}}})
   ) u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .async_in (sync_in),
      .sync_out (sync_out)
   );

   assign {cs_n_s, gnd_lost_s, clr_tog_s, arm_tog_s, cmd_tog_s,
           vds_s, dyn_s, ol_s, ot_s, on_s} = sync_out;

   // ==========================================================
   // core domain: event detection
   logic clr_prev_q;
   logic arm_prev_q;
   logic cmd_prev_q;
   logic cs_prev_q;
   logic clr_evt;
   logic arm_evt;
   logic cmd_evt;
   logic frame_start;

   // previous values are caught at reset so a stale toggle gives no event
   always_ff @(posedge core_clk) begin
      clr_prev_q <= clr_tog_s;
      arm_prev_q <= arm_tog_s;
      cmd_prev_q <= cmd_tog_s;
      cs_prev_q  <= rst ? 1'b1 : cs_n_s;
   end

   assign clr_evt     = !rst && (clr_tog_s != clr_prev_q);
   assign arm_evt     = !rst && (arm_tog_s != arm_prev_q);
   assign cmd_evt     = !rst && (cmd_tog_s != cmd_prev_q);
   assign frame_start = cs_prev_q && !cs_n_s;

   // ==========================================================
   // command decode
   logic clr_latch_cmd;
   logic sel_wr_cmd;
   logic ctrl_rd_cmd;

   assign clr_latch_cmd = cmd_evt && cmd_word_q[FW-1:2] == fld_pkg::HW_CFG_PAT
                          && cmd_word_q[fld_pkg::CLR_LATCH_BIT];
   assign sel_wr_cmd    = cmd_evt && cmd_word_q[FW-1:3] == fld_pkg::SEL_WR_PAT;
   assign ctrl_rd_cmd   = cmd_evt && cmd_word_q == fld_pkg::CTRL_RD_CMD;

   // ==========================================================
   // thermal latches and gate control
   logic [N_CH-1:0] ot_latch_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ot_latch_q <= '0;
      end else begin
         // a still-hot channel relatches even in the clearing cycle
         ot_latch_q <= (ot_latch_q & ~{N_CH{clr_latch_cmd}}) | ot_s;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         gate_on       <= '0;
         thermal_latch <= '0;
      end else begin
         gate_on       <= on_s & ~ot_latch_q & ~{N_CH{gnd_lost_s}};
         thermal_latch <= ot_latch_q;
      end
   end

   // ==========================================================
   // overload flags and thermal copy
   logic [N_CH-1:0] ol_q;
   logic [N_CH-1:0] ol_set;
   logic [N_CH-1:0] otc_q;
   logic            clr_pend_q;
   logic            block_q;
   logic            ctrl_frame_q;
   logic            ol_clr;

   assign ol_set = (ol_s | dyn_s) & on_s;
   assign ol_clr = clr_evt && !ctrl_frame_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ol_q <= '0;
      end else begin
         ol_q <= (ol_q & ~{N_CH{ol_clr}}) | ol_set;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         clr_pend_q <= 1'b0;
         block_q    <= 1'b0;
         otc_q      <= '0;
      end else begin
         if (clr_latch_cmd) begin
            clr_pend_q <= 1'b1;
         end else if (clr_evt && clr_pend_q) begin
            clr_pend_q <= 1'b0;
         end
         if (clr_evt && clr_pend_q) begin
            block_q <= 1'b1;
         end else if (arm_evt) begin
            block_q <= 1'b0;
         end
         if ((clr_evt && clr_pend_q) || block_q) begin
            otc_q <= '0;
         end else begin
            otc_q <= otc_q | ot_latch_q;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         channel_error_flag <= '0;
      end else begin
         channel_error_flag <= ol_q | otc_q;
      end
   end

   // ==========================================================
   // sense selection and bypass monitor
   logic [SW-1:0] sel_q;
   logic          ctrl_rd_pend_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sel_q <= fld_pkg::SEL_RESET;
      end else if (sel_wr_cmd) begin
         sel_q <= cmd_word_q[SW-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sense_output_sel <= '0;
         sense_output_en  <= 1'b0;
      end else begin
         sense_output_en  <= sel_q < SW'(N_CH);
         for (int i = 0; i < N_CH; i++) begin
            sense_output_sel[i] <= sel_q == SW'(i);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         bypass_monitor_result <= 1'b0;
      end else if (sel_q < SW'(N_CH)) begin
         bypass_monitor_result <= vds_s[sel_q];
      end else begin
         bypass_monitor_result <= 1'b0;
      end
   end

   // ==========================================================
   // response word, frozen at frame start for the link domain
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl_rd_pend_q <= 1'b0;
         ctrl_frame_q   <= 1'b0;
         resp_q         <= '0;
      end else begin
         if (ctrl_rd_cmd) begin
            ctrl_rd_pend_q <= 1'b1;
         end else if (frame_start) begin
            ctrl_rd_pend_q <= 1'b0;
         end
         if (frame_start) begin
            ctrl_frame_q <= ctrl_rd_pend_q;
            if (ctrl_rd_pend_q) begin
               resp_q <= {4'h0, bypass_monitor_result, sel_q};
            end else begin
               resp_q <= FW'(ol_q | otc_q);
            end
         end
      end
   end

   // ==========================================================
   // checks
   property p_gate_off_hot;
      @(posedge core_clk) disable iff (rst)
      (ot_latch_q != '0) |=> ((gate_on & $past(ot_latch_q)) == '0);
   endproperty
   a_gate_off_hot: assert property (p_gate_off_hot)
      else $error("hot channel left switched on");

   property p_latch_clears;
      @(posedge core_clk) disable iff (rst)
      clr_latch_cmd |=> ot_latch_q == $past(ot_s);
   endproperty
   a_latch_clears: assert property (p_latch_clears)
      else $error("thermal latches not cleared by command");

   property p_err_or;
      @(posedge core_clk) disable iff (rst)
      ##1 channel_error_flag == $past(ol_q | otc_q);
   endproperty
   a_err_or: assert property (p_err_or)
      else $error("error flag differs from overload or thermal copy");

   property p_ol_clear;
      @(posedge core_clk) disable iff (rst)
      (ol_clr && ol_set == '0) |=> ol_q == '0;
   endproperty
   a_ol_clear: assert property (p_ol_clear)
      else $error("overload flags kept after diagnosis sent");

   property p_clr_edge;
      @(posedge sclk) disable iff (rst || cs_n)
      rise_cnt_q == fld_pkg::CLR_EDGE |=> clr_tog_q != $past(clr_tog_q);
   endproperty
   a_clr_edge: assert property (p_clr_edge)
      else $error("clear event not raised at second rising edge");

   property p_block_zero;
      @(posedge core_clk) disable iff (rst)
      block_q |-> otc_q == '0;
   endproperty
   a_block_zero: assert property (p_block_zero)
      else $error("thermal copy set while blocked");

   property p_ol_reset;
      @(posedge core_clk) disable iff (rst)
      (ol_set != '0) |=> ((ol_q & $past(ol_set)) == $past(ol_set));
   endproperty
   a_ol_reset: assert property (p_ol_reset)
      else $error("persisting overload not flagged again");

   property p_gnd_lost;
      @(posedge core_clk) disable iff (rst)
      gnd_lost_s [*2] |-> gate_on == '0;
   endproperty
   a_gnd_lost: assert property (p_gnd_lost)
      else $error("output on after ground loss");

   property p_sense_onehot;
      @(posedge core_clk) disable iff (rst)
      sense_output_en |-> $onehot(sense_output_sel);
   endproperty
   a_sense_onehot: assert property (p_sense_onehot)
      else $error("sense routing not exactly one channel");

   property p_sel_disable;
      @(posedge core_clk) disable iff (rst)
      sel_q == fld_pkg::SEL_DISABLE |=> !sense_output_en && sense_output_sel == '0;
   endproperty
   a_sel_disable: assert property (p_sel_disable)
      else $error("sense not disabled by code 110");

   property p_sbm_follow;
      @(posedge core_clk) disable iff (rst)
      (sel_q == '0) |=> bypass_monitor_result == $past(vds_s[0]);
   endproperty
   a_sbm_follow: assert property (p_sbm_follow)
      else $error("bypass monitor not from channel 0");

endmodule

// ==== inc/fld_pkg.sv ====
// Purpose : shared constants for the five-channel fault latch and diagnosis block
// Assumes : 8-bit serial frames, command decoded after the eighth falling clock edge
// Notes   : command codes for the diagnosis control register are local encodings
//
// Function
// - an overheated channel stays off through its own thermal latch at gate control
// - command bit 0 set clears all thermal latches at once; bit 0 clear leaves them
// - each error bit is thermal flag copy OR latched overload signal
// - overload events stay latched until the diagnosis word has been sent, then clear
// - overload clear happens between the second and third rising serial clock edge
// - after clear-latch command the thermal copy clears next frame, rearms after third edge
// - first diagnosis word after clear-latch still shows the old thermal fault
// - a persisting overload sets the error flag again right after its clear
// - thermal flag latches whether channel is on or off; only clear-latch removes it
// - on loss of device ground every output goes or stays off
// - commanded off: error bit 0 (code still sets it from a latched thermal fault); bypass bit 1 normal/short-to-ground, 0 short-to-battery
// - commanded on: error bit 1 on limit, short to ground, thermal; else 0
// - commanded on: bypass bit 1 for short to ground, 0 normal/battery/open load
// - exactly one selected channel's sense signal is routed to the sense pin
// - the sense output can be disabled through the selection field
// - a bypass monitor status bit is readable over the serial link
// - selection code 110 disables sense, code 000 selects channel 0
// - dynamic thermal shutdown sets the error flag; read clears; persisting sets again
package fld_pkg;

   // ==========================================================
   // geometry
   localparam int unsigned N_CH       = 5;
   localparam int unsigned FRAME_W    = 8;
   localparam int unsigned SEL_W      = 3;
   localparam int unsigned CNT_W      = 4;

   // ==========================================================
   // command encodings
   localparam logic [5:0] HW_CFG_PAT    = 6'h30;   // bits 7..2 of hardware_config_command
   localparam int unsigned CLR_LATCH_BIT = 0;
   localparam logic [4:0] SEL_WR_PAT    = 5'h1C;   // bits 7..3, select in bits 2..0
   localparam logic [7:0] CTRL_RD_CMD   = 8'h70;   // next frame returns the control register

   // ==========================================================
   // sense selection
   localparam logic [2:0] SEL_DISABLE = 3'h6;
   localparam logic [2:0] SEL_RESET   = 3'h6;

   // ==========================================================
   // serial clock edge indices (edges counted from zero)
   localparam logic [3:0] CLR_EDGE    = 4'h1;    // second rising edge
   localparam logic [3:0] ARM_EDGE    = 4'h2;    // third rising edge
   localparam logic [3:0] LAST_FALL   = 4'h7;    // eighth falling edge
   localparam logic [3:0] CNT_SAT     = 4'hF;

endpackage

// ==== hdl/fld_sync.sv ====
// Purpose : two-stage synchroniser for a bundle of level signals
// Assumes : inputs are quasi-static levels or toggles from another domain
// Notes   : first stage feeds only the second stage
module fld_sync #(
   parameter int unsigned WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_q   <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

// ==== verification/fld_spi_host.sv ====
// Purpose : serial link host that sends one byte a frame and returns the byte read back
// Assumes : 48 ns serial clock, device shifts out on rising and samples on falling edges
// Notes   : clock stands low between frames; mosi toggles while deselected
module fld_spi_host (
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso,
   input  wire logic miso_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   localparam int HALF = 24;

   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end

   // a released data line must not look like a held bit to the device
   always #37 if (cs_n) mosi = ~mosi;

   // ==========================================================
   // one frame, msb first both ways
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      rx   = 8'h00;
      cs_n = 1'b0;
      #53;  // select setup above the 30 ns the core needs to freeze its answer
      for (int i = 7; i >= 0; i--) begin
         sclk = 1'b1;
         mosi = tx[i];
         #HALF;
         rx[i] = (miso_oe === 1'b1) ? miso : 1'bx;
         sclk  = 1'b0;
         #HALF;
      end
      cs_n = 1'b1;
      #50;
   endtask
endmodule

// ==== verification/tb_fault_latch_diagnosis.sv ====
// Purpose : self-checking bench for the fault latch and diagnosis core
// Assumes : core inputs change on falling core_clk; link traffic from the host model
// Notes   : waits of 6 core cycles cover the 3-5 cycle latency from the inputs through the synchroniser
module tb_fault_latch_diagnosis;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int N = fld_pkg::N_CH;

   logic          core_clk;
   logic          rst;
   logic          sclk;
   logic          cs_n;
   logic          mosi;
   logic          miso_o;
   logic          miso_oe;
   logic          ground_lost;
   logic [N-1:0]  chan_on_cmd;
   logic [N-1:0]  over_temp;
   logic [N-1:0]  over_load;
   logic [N-1:0]  dyn_temp_off;
   logic [N-1:0]  vds_above_thr;
   logic [N-1:0]  gate_on;
   logic [N-1:0]  thermal_latch;
   logic [N-1:0]  channel_error_flag;
   logic [N-1:0]  sense_output_sel;
   logic          sense_output_en;
   logic          bypass_monitor_result;
   logic [7:0]    rx;
   int            err_total   = 0;
   int            comparisons = 0;
   int            cycles      = 0;

   fld_core #(.N_CH(N)) i_fld_core (
      .core_clk(core_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
      .miso_o(miso_o), .miso_oe(miso_oe), .chan_on_cmd(chan_on_cmd),
      .over_temp(over_temp), .over_load(over_load), .dyn_temp_off(dyn_temp_off),
      .vds_above_thr(vds_above_thr), .ground_lost(ground_lost), .gate_on(gate_on),
      .thermal_latch(thermal_latch), .channel_error_flag(channel_error_flag),
      .sense_output_sel(sense_output_sel), .sense_output_en(sense_output_en),
      .bypass_monitor_result(bypass_monitor_result));

   fld_spi_host i_fld_spi_host (
      .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_o), .miso_oe(miso_oe));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ==========================================================
   // checking and closing
   task automatic give_verdict();
      if (err_total == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         give_verdict();
      end
   end

   task automatic chk_flags(string what, logic [N-1:0] exp, logic [N-1:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_byte(string what, logic [7:0] exp, logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic settle();
      repeat (6) @(negedge core_clk);
   endtask

   task automatic frame(logic [7:0] tx);
      @(negedge core_clk);
      i_fld_spi_host.xfer(tx, rx);
      settle();
   endtask

   function automatic logic [7:0] exp_diag(logic [N-1:0] err);
      return {3'h0, err};
   endfunction

   function automatic logic [N-1:0] exp_sel(logic [2:0] code);
      return (code < 3'h5) ? (5'h01 << code) : 5'h00;
   endfunction

   // ==========================================================
   // main sequence
   initial begin
      logic [N-1:0] pick;
      logic [N-1:0] on;
      logic [N-1:0] exp;
      logic         keep;
      logic         bp;
      void'($urandom(32'h2668AFEE));
      rst           = 1'b1;
      ground_lost   = 1'b0;
      chan_on_cmd   = '0;
      over_temp     = '0;
      over_load     = '0;
      dyn_temp_off  = '0;
      vds_above_thr = '0;
      repeat (10) @(negedge core_clk);
      chk_flags("err after reset", 5'h00, channel_error_flag);
      chk_flags("sel after reset", 5'h00, sense_output_sel);
      rst = 1'b0;
      settle();

      // overload and dynamic shutdown: latch, report, clear on send, re-set if held
      for (int k = 0; k < 10; k++) begin
         pick = '0;
         pick[$urandom_range(N-1)] = 1'b1;
         on   = N'($urandom) | ((k < 2) ? pick : 5'h00);
         chan_on_cmd = on;
         if ($urandom_range(1)) over_load = pick;
         else dyn_temp_off = pick;
         settle();
         exp = pick & on;
         chk_flags("err raised", exp, channel_error_flag);
         keep = ($urandom_range(1) == 1);
         if (!keep) begin
            over_load    = '0;
            dyn_temp_off = '0;
            settle();
         end
         chk_flags("err held", exp, channel_error_flag);
         frame(8'h00);
         chk_byte("diag word", exp_diag(exp), rx);
         chk_flags("err after send", keep ? exp : 5'h00, channel_error_flag);
         over_load    = '0;
         dyn_temp_off = '0;
         frame(8'h00);
      end

      // thermal latch: independent per channel, cleared only by the command
      pick = N'($urandom) | 5'h01;
      on   = N'($urandom);
      chan_on_cmd = on;
      over_temp   = pick;
      settle();
      chk_flags("latch set", pick, thermal_latch);
      chk_flags("gate off", on & ~pick, gate_on);
      chk_flags("err thermal", pick, channel_error_flag);
      over_temp = '0;
      frame(8'h00);
      chk_byte("diag thermal", exp_diag(pick), rx);
      chk_flags("err kept", pick, channel_error_flag);
      frame(8'hC2);
      chk_flags("latch no clear", pick, thermal_latch);
      frame(8'hC1);
      chk_flags("latch cleared", 5'h00, thermal_latch);
      chk_flags("gate back", on, gate_on);
      frame(8'h00);
      chk_byte("first diag", exp_diag(pick), rx);
      chk_flags("err copy cleared", 5'h00, channel_error_flag);
      frame(8'h00);
      chk_byte("second diag", 8'h00, rx);

      // loss of ground
      chan_on_cmd = '1;
      ground_lost = 1'b1;
      settle();
      chk_flags("gate ground lost", 5'h00, gate_on);
      ground_lost = 1'b0;
      settle();
      chk_flags("gate ground back", 5'h1F, gate_on);

      // every selection code, with the bypass bit of the chosen channel
      for (int c = 0; c < 8; c++) begin
         vds_above_thr = N'($urandom);
         frame(8'hE0 | 8'(c));
         bp = (c < N) ? vds_above_thr[c] : 1'b0;
         chk_flags("sense sel", exp_sel(3'(c)), sense_output_sel);
         chk_flags("sense en", {4'h0, c < N}, {4'h0, sense_output_en});
         chk_flags("bypass", {4'h0, bp}, {4'h0, bypass_monitor_result});
         frame(8'h70);
         frame(8'h00);
         chk_byte("ctrl readback", {4'h0, bp, 3'(c)}, rx);
      end
      give_verdict();
   end
endmodule
